/* File: design/rhc_host.sv */
// Function
// - host keeps output gate high for all write cycles
// - 64 consecutive key writes on the lowest data bit unlock the clock
// - one read cycle first resets the key pointer, before the key writes
// - host sends every key write to one scratch address
// - host handles each clock register as a whole group of eight bits
// - transfer steps bit 0 of register 0 to bit 7 of register 7
// - key is C5, 3A, A3, 5C twice, lsb first
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module rhc_host
  import rhc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [18:0] byte_address_lines_o,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  input wire logic [7:0] dq_i,
  output logic xfer_abort_n_o,
  input wire logic power_fail_threshold_i
);

  rhc_state_s s_r;
  rhc_state_s s_nxt;
  logic buf_we;
  logic [2:0] buf_waddr;
  logic [7:0] buf_wdata;
  logic [2:0] buf_raddr;
  logic [7:0] buf_rdata;
  logic busy;
  logic is_write;
  logic [7:0] drive_byte;
  logic [7:0] sh_in;
  logic [31:0] rd_mux;

  // key bit for a given pointer position, lsb of byte 0 first
  function automatic logic key_bit(input logic [5:0] idx);
    key_bit = UNLOCK_KEY[idx];
  endfunction : key_bit

  // true on the last cycle of a phase lasting n cycles
  function automatic logic phase_last(input logic [3:0] cnt, input int n);
    phase_last = (cnt == 4'(n - 1));
  endfunction : phase_last

  rhc_clkbuf #(
    .DEPTH(CLK_REGS),
    .AW(3)
  ) u_clkbuf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(buf_we),
    .waddr_i(buf_waddr),
    .wdata_i(buf_wdata),
    .raddr_i(buf_raddr),
    .rdata_o(buf_rdata)
  );

  assign busy = (s_r.op != OP_IDLE);
  // the sequencer owns the buffer read port while it runs
  assign buf_raddr = busy ? s_r.bcnt[5:3] : wb_adr_i[4:2];

  // direction of the current device cycle; the pointer reset is always a read
  always_comb begin
    unique case (s_r.op)
      OP_KEY: is_write = 1'b1;
      OP_XFER: is_write = (s_r.cmd == CMD_CLK_WR);
      OP_MEM: is_write = (s_r.cmd == CMD_MEM_WR);
      default: is_write = 1'b0;
    endcase
  end

  // byte put on the data lines for a write cycle
  always_comb begin
    unique case (s_r.op)
      OP_KEY: drive_byte = {7'h00, key_bit(s_r.bcnt)};
      OP_XFER: drive_byte = {7'h00, buf_rdata[s_r.bcnt[2:0]]};
      default: drive_byte = s_r.wdata;
    endcase
  end

  // shift in lsb first so each byte lands in natural order
  assign sh_in = {dq_i[0], s_r.sh[7:1]};

  // register read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    if ((wb_adr_i & CLKBUF_MASK) == OFS_CLKBUF) begin
      rd_mux = {24'h00_0000, buf_rdata};
    end else begin
      unique case (wb_adr_i)
        OFS_CTRL: rd_mux = {29'h0000_0000, s_r.cmd, 1'b0};
        OFS_STAT: rd_mux = {28'h000_0000, power_fail_threshold_i, s_r.err, s_r.done, busy};
        OFS_ADDR: rd_mux = {13'h0000, s_r.addr};
        OFS_SCRATCH: rd_mux = {13'h0000, s_r.scratch};
        OFS_WDATA: rd_mux = {24'h00_0000, s_r.wdata};
        OFS_RDATA: rd_mux = {24'h00_0000, s_r.rdata};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // next state: bus slave first, sequencer after so its flag sets win
  always_comb begin
    s_nxt = s_r;
    buf_we = 1'b0;
    buf_waddr = s_r.bcnt[5:3];
    buf_wdata = sh_in;
    s_nxt.ack = 1'b0;
    s_nxt.pins.abort_n = 1'b1; // transfers are never cut short from this side
    if (wb_cyc_i && wb_stb_i && !s_r.pend && !s_r.ack) begin
      s_nxt.pend = 1'b1;
    end
    if (s_r.pend) begin
      s_nxt.pend = 1'b0;
      s_nxt.ack = 1'b1;
      s_nxt.dat = rd_mux;
      if (wb_we_i && wb_sel_i[0]) begin
        if ((wb_adr_i & CLKBUF_MASK) == OFS_CLKBUF) begin
          // buffer writes are dropped while busy so a transfer never sees a torn byte
          buf_we = !busy;
          buf_waddr = wb_adr_i[4:2];
          buf_wdata = wb_dat_i[7:0];
        end else begin
          unique case (wb_adr_i)
            OFS_CTRL: begin
              if (!busy && wb_dat_i[CTRL_GO]) begin
                s_nxt.cmd = rhc_cmd_e'(wb_dat_i[CTRL_CMD_LSB +: 2]);
                s_nxt.done = 1'b0;
                s_nxt.err = power_fail_threshold_i;
                if (!power_fail_threshold_i) begin
                  // clock access always opens with the pointer reset read
                  s_nxt.op = wb_dat_i[CTRL_CMD_LSB + 1] ? OP_PTR : OP_MEM;
                  s_nxt.ph = PH_SETUP;
                  s_nxt.tcnt = 4'h0;
                  s_nxt.bcnt = 6'h00;
                end
              end
            end
            OFS_STAT: begin
              if (wb_dat_i[STAT_DONE]) begin
                s_nxt.done = 1'b0;
              end
              if (wb_dat_i[STAT_ERR]) begin
                s_nxt.err = 1'b0;
              end
            end
            OFS_ADDR: s_nxt.addr = busy ? s_r.addr : wb_dat_i[18:0];
            OFS_SCRATCH: s_nxt.scratch = busy ? s_r.scratch : wb_dat_i[18:0];
            OFS_WDATA: s_nxt.wdata = busy ? s_r.wdata : wb_dat_i[7:0];
            default: s_nxt.wdata = s_r.wdata; // unmapped or read-only: ignored
          endcase
        end
      end
    end
    // device cycle sequencer
    if (busy) begin
      s_nxt.tcnt = s_r.tcnt + 4'h1;
      unique case (s_r.ph)
        PH_SETUP: begin
          s_nxt.pins.addr = (s_r.op == OP_MEM) ? s_r.addr : s_r.scratch;
          s_nxt.pins.dq_oe = 1'b0;
          if (power_fail_threshold_i) begin
            // no strobe is started while the device would block it
            s_nxt.op = OP_IDLE;
            s_nxt.err = 1'b1;
            s_nxt.tcnt = 4'h0;
          end else if (phase_last(s_r.tcnt, SETUP_CYC)) begin
            s_nxt.ph = PH_STROBE;
            s_nxt.tcnt = 4'h0;
            s_nxt.pins.ce_n = 1'b0;
            if (is_write) begin
              s_nxt.pins.we_n = 1'b0;
              s_nxt.pins.oe_n = 1'b1;
              s_nxt.pins.dq_oe = 1'b1;
              s_nxt.pins.dq = drive_byte;
            end else begin
              s_nxt.pins.oe_n = 1'b0;
            end
          end
        end
        PH_STROBE: begin
          if (phase_last(s_r.tcnt, STROBE_CYC)) begin
            s_nxt.ph = PH_RECOV;
            s_nxt.tcnt = 4'h0;
            // earliest rising edge ends the write; both rise together here
            s_nxt.pins.ce_n = 1'b1;
            s_nxt.pins.we_n = 1'b1;
            s_nxt.pins.oe_n = 1'b1;
            if (!is_write && s_r.op == OP_MEM) begin
              s_nxt.rdata = dq_i;
            end
            if (!is_write && s_r.op == OP_XFER) begin
              s_nxt.sh = sh_in;
              if (s_r.bcnt[2:0] == 3'h7) begin
                buf_we = 1'b1;
                buf_waddr = s_r.bcnt[5:3];
                buf_wdata = sh_in;
              end
            end
          end
        end
        PH_RECOV: begin
          if (phase_last(s_r.tcnt, RECOV_CYC)) begin
            s_nxt.ph = PH_SETUP;
            s_nxt.tcnt = 4'h0;
            s_nxt.pins.dq_oe = 1'b0; // data held through recovery for hold time
            s_nxt.bcnt = s_r.bcnt + 6'h01;
            unique case (s_r.op)
              OP_PTR: begin
                s_nxt.op = OP_KEY;
                s_nxt.bcnt = 6'h00;
              end
              OP_KEY: begin
                if (s_r.bcnt == 6'(KEY_BITS - 1)) begin
                  s_nxt.op = OP_XFER;
                  s_nxt.bcnt = 6'h00;
                end
              end
              OP_XFER: begin
                if (s_r.bcnt == 6'(XFER_BITS - 1)) begin
                  s_nxt.op = OP_IDLE;
                  s_nxt.done = 1'b1;
                end
              end
              default: begin
                s_nxt.op = OP_IDLE;
                s_nxt.done = 1'b1;
              end
            endcase
          end
        end
        default: begin
          s_nxt.ph = PH_SETUP;
          s_nxt.tcnt = 4'h0;
        end
      endcase
    end
  end

  // single state register; strobes idle high, data lines released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.cmd <= CMD_MEM_RD;
      s_r.addr <= ADDR_RST;
      s_r.scratch <= SCRATCH_RST;
      s_r.op <= OP_IDLE;
      s_r.ph <= PH_SETUP;
      s_r.pins.ce_n <= 1'b1;
      s_r.pins.oe_n <= 1'b1;
      s_r.pins.we_n <= 1'b1;
      s_r.pins.abort_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign ce_n_o = s_r.pins.ce_n;
  assign oe_n_o = s_r.pins.oe_n;
  assign we_n_o = s_r.pins.we_n;
  assign byte_address_lines_o = s_r.pins.addr;
  assign dq_o = s_r.pins.dq;
  assign dq_oe_o = s_r.pins.dq_oe;
  assign xfer_abort_n_o = s_r.pins.abort_n;

endmodule : rhc_host
`default_nettype wire

/* File: design/rhc_pkg.sv */
package rhc_pkg;

  // bus clock
  localparam int CLK_NS = 100;

  // strobe timing toward the memory module, in ns, and derived cycle counts
  localparam int T_SETUP_NS = 150;
  localparam int T_STROBE_NS = 200;
  localparam int T_RECOV_NS = 100;
  localparam int SETUP_CYC = ((T_SETUP_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
                             (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = ((T_STROBE_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
                              (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC = ((T_RECOV_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
                             (T_RECOV_NS + CLK_NS - 1) / CLK_NS;

  // device geometry
  localparam int ADDR_W = 19;
  localparam int CLK_REGS = 8;
  localparam int KEY_BITS = 64;
  localparam int XFER_BITS = 64;

  // unlock key, byte 0 in the low bits, shifted out lsb first
  localparam logic [63:0] UNLOCK_KEY = 64'h5ca3_3ac5_5ca3_3ac5;

  // register byte offsets on the wishbone side
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_SCRATCH = 8'h0c;
  localparam logic [7:0] OFS_WDATA = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  localparam logic [7:0] OFS_CLKBUF = 8'h20;
  localparam logic [7:0] CLKBUF_MASK = 8'he0;

  // ctrl fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_CMD_LSB = 1;
  // stat fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_PF = 3;

  // reset values
  localparam logic [18:0] ADDR_RST = 19'h00000;
  localparam logic [18:0] SCRATCH_RST = 19'h7ffff;

  typedef enum logic [1:0] {
    CMD_MEM_RD = 2'b00,
    CMD_MEM_WR = 2'b01,
    CMD_CLK_RD = 2'b10,
    CMD_CLK_WR = 2'b11
  } rhc_cmd_e;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b000,
    OP_PTR = 3'b001,
    OP_KEY = 3'b010,
    OP_XFER = 3'b011,
    OP_MEM = 3'b100
  } rhc_op_e;

  typedef enum logic [1:0] {
    PH_SETUP = 2'b00,
    PH_STROBE = 2'b01,
    PH_RECOV = 2'b10
  } rhc_ph_e;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [18:0] addr;
    logic [7:0] dq;
    logic dq_oe;
    logic abort_n;
  } rhc_pins_s;

  typedef struct packed {
    logic ack;
    logic pend;
    logic [31:0] dat;
    rhc_cmd_e cmd;
    logic [18:0] addr;
    logic [18:0] scratch;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
    logic err;
    rhc_op_e op;
    rhc_ph_e ph;
    logic [3:0] tcnt;
    logic [5:0] bcnt;
    logic [7:0] sh;
    rhc_pins_s pins;
  } rhc_state_s;

endpackage : rhc_pkg

/* File: design/rhc_clkbuf.sv */
`timescale 1ns/1ps
`default_nettype none
// image of the eight clock registers; read data comes from a register
module rhc_clkbuf #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem_r [DEPTH];

  // array has no reset: contents are only meaningful after a clock read or a bus write
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule : rhc_clkbuf
`default_nettype wire

/* File: tb/rhc_host_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the bus handshake and the device strobes
module rhc_host_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic ce_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic [18:0] byte_address_lines_o,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe_o,
  input wire logic xfer_abort_n_o,
  input wire logic power_fail_threshold_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // fixed answer latency keeps software polling simple
  ack_latency_a: assert property ($rose(wb_stb_i) && wb_cyc_i |-> (!wb_ack_o)[*2] ##1 wb_ack_o)
    else $error("ack latency wrong");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  pair_strobe_a: assert property (ce_n_o ? (oe_n_o && we_n_o) : (oe_n_o ^ we_n_o))
    else $error("strobe pairing wrong");
  drive_gate_a: assert property (dq_oe_o |-> oe_n_o)
    else $error("host drives while gate low");
  strobe_width_a: assert property ($fell(ce_n_o) |=> !ce_n_o ##1 ce_n_o)
    else $error("strobe width wrong");
  addr_hold_a: assert property (!ce_n_o && $past(!ce_n_o) |-> $stable(byte_address_lines_o))
    else $error("address moved in strobe");
  wr_data_a: assert property (!we_n_o |-> dq_oe_o ##1 (we_n_o || $stable(dq_o)))
    else $error("write data not held");
  pf_block_a: assert property (power_fail_threshold_i && ce_n_o |=> ce_n_o)
    else $error("strobe under power fail");
  abort_idle_a: assert property (xfer_abort_n_o)
    else $error("abort pin asserted");
endmodule : rhc_host_props

bind rhc_host rhc_host_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
  .byte_address_lines_o(byte_address_lines_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
  .xfer_abort_n_o(xfer_abort_n_o), .power_fail_threshold_i(power_fail_threshold_i)
);
`default_nettype wire

/* File: tb/rhc_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural memory with hidden clock; strobes sampled on clk for determinism
module rhc_dev_model (
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [18:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic pf_i,
  output logic [7:0] dq_o
);
  localparam logic [63:0] KEY = {2{8'h5c, 8'ha3, 8'h3a, 8'hc5}};
  logic [7:0] mem [logic [18:0]];
  logic [7:0] rtc [8];
  logic open_r, miss_r, act, wr, blk;
  logic [6:0] ptr, bcnt;
  logic [7:0] d, rd;
  logic [18:0] a;
  // bcd contents, day bits 5:4 as shipped; oscillator stopped so no counting
  initial begin
    rtc = '{8'h42, 8'h59, 8'h30, 8'h11, 8'h33, 8'h28, 8'h02, 8'h24};
    {open_r, miss_r, act, blk, ptr, bcnt} = {4'b0100, 14'h0};
  end
  // read byte settles on the falling edge, away from the host sampling edge
  always @(negedge clk_i) begin
    rd = open_r ? {7'h0, rtc[bcnt[5:3]][bcnt[2:0]]} :
      (mem.exists(addr_i) ? mem[addr_i] : 8'h00);
  end
  // released bus shows the inverse so a late sample cannot pass by luck
  assign dq_o = (!ce_n_i && !oe_n_i && we_n_i && !pf_i) ? rd : ~rd;
  // a cycle is judged when chip select returns high
  always @(posedge clk_i) begin
    if (!ce_n_i) begin // only chip-select cycles move the sequence
      act = 1;
      wr = !we_n_i;
      a = addr_i;
      d = dq_i;
      blk = blk | pf_i;
    end else if (act) begin
      act = 0;
      if (!blk) begin
        if (open_r) begin
          if (wr) rtc[bcnt[5:3]][bcnt[2:0]] = d[0];
          bcnt = bcnt + 7'h1;
          open_r = (bcnt != 7'h40);
        end else if (wr) begin
          mem[a] = d;
          if (!miss_r && d[0] === KEY[ptr[5:0]]) ptr = ptr + 7'h1;
          else miss_r = 1;
          if (ptr == 7'h40) begin
            {open_r, miss_r, ptr, bcnt} = {2'b11, 14'h0};
          end
        end else begin
          ptr = 0;
          miss_r = 0;
        end
      end
      blk = 0;
    end
  end
endmodule : rhc_dev_model
`default_nettype wire

/* File: tb/test_sram_hidden_clock_access.sv */
`timescale 1ns/1ps
`default_nettype none
module test_sram_hidden_clock_access;
  import rhc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pf = 0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ce_n, oe_n, we_n, dq_oe, abort_n;
  logic [18:0] addr;
  logic [7:0] dq_h, dq_d;
  wire logic [7:0] bus_w;
  int n_fail = 0, num_checks = 0;
  logic [7:0] t0 [8] = '{8'h17, 8'h45, 8'h08, 8'hb1, // 12-hour, pm, eleven
    8'h32, 8'h31, 8'h12, 8'h99};
  logic [7:0] t1 [8] = '{8'h00, 8'h30, 8'h59, 8'h23, // 24-hour, twenties digit
    8'h36, 8'h29, 8'h02, 8'h00}; // leap-day date, bcd fields
  always #50 clk_i = ~clk_i;
  // the wire carries whichever side has its driver on
  assign bus_w = dq_oe ? dq_h : dq_d;
  rhc_host u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
    .byte_address_lines_o(addr), .dq_o(dq_h), .dq_oe_o(dq_oe), .dq_i(bus_w),
    .xfer_abort_n_o(abort_n), .power_fail_threshold_i(pf));
  rhc_dev_model u_dev (.clk_i(clk_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .addr_i(addr), .dq_i(bus_w), .pf_i(pf), .dq_o(dq_d));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle; request held until ack is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) chk("ack", 1, 0);
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(0, a, 0);
    chk(nm, e, q);
  endtask : rdc
  // polls status until done or error shows, bounded
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      bus(0, OFS_STAT, 0);
      n++;
    end while (q[2:1] === 2'b00 && n < 400);
    // a command that never finishes must not slip through silently
    if (n >= 400) chk("wait_done", 1, 0);
  endtask : wait_done
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #2000000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    u_dev.rtc = t0;
    @(posedge clk_i);
    // reset values and an unmapped hole
    rdc(OFS_ADDR, 0, "addr");
    rdc(OFS_SCRATCH, 32'h7ffff, "scratch");
    rdc(OFS_STAT, 0, "stat");
    rdc(8'h18, 0, "hole");
    // memory write, then a read of a byte changed behind the host
    bus(1, OFS_ADDR, 32'h12345);
    bus(1, OFS_WDATA, 32'ha5);
    bus(1, OFS_CTRL, 32'h3);
    wait_done();
    chk("mem", 32'ha5, u_dev.mem[19'h12345]);
    u_dev.mem[19'h12345] = 8'h3c;
    bus(1, OFS_CTRL, 32'h1);
    wait_done();
    rdc(OFS_RDATA, 32'h3c, "rdata");
    // clock read; an address write while busy must be dropped
    u_dev.mem[19'h7ffff] = 8'hff;
    bus(1, OFS_CTRL, 32'h5);
    rdc(OFS_STAT, 32'h1, "busy");
    rdc(OFS_CTRL, 32'h4, "ctrl");
    bus(1, OFS_ADDR, 32'h00777);
    wait_done();
    rdc(OFS_ADDR, 32'h12345, "busy_addr");
    for (int i = 0; i < 8; i++) begin
      rdc(OFS_CLKBUF + 8'(i * 4), t0[i], "clkbuf");
    end
    chk("key_store", 0, u_dev.mem[19'h7ffff]);
    chk("relock", 0, u_dev.open_r);
    // clock write of whole registers
    for (int i = 0; i < 8; i++) bus(1, OFS_CLKBUF + 8'(i * 4), t1[i]);
    bus(1, OFS_CTRL, 32'h7);
    wait_done();
    for (int i = 0; i < 8; i++) chk("rtc", t1[i], u_dev.rtc[i]);
    // power fail refuses the operation and leaves memory alone
    pf <= 1;
    bus(1, OFS_WDATA, 32'h99);
    bus(1, OFS_CTRL, 32'h3);
    wait_done();
    chk("err", 1, q[STAT_ERR]);
    chk("pf", 1, q[STAT_PF]);
    chk("pf_mem", 32'h3c, u_dev.mem[19'h12345]);
    pf <= 0;
    bus(1, OFS_STAT, 32'h6);
    rdc(OFS_STAT, 0, "stat_clr");
    final_report();
  end
endmodule : test_sram_hidden_clock_access
`default_nettype wire
